// >>> verilog/frsv_pkg.sv
package frsv_pkg;
	// ---------------------------------------------------------------
	// Clock and time base
	// ---------------------------------------------------------------
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned BASE_TICK_US  = 10_000;
	localparam int unsigned BASE_TICK_CYC = CLK_HZ / 1_000_000 * BASE_TICK_US;
	localparam int unsigned SLOW_PER_BASE = 10;
	localparam int unsigned RECOVERY_S    = 60;
	localparam int unsigned RECOVERY_TICKS = RECOVERY_S * 10;
	localparam int unsigned REC_W         = 10;

	// ---------------------------------------------------------------
	// Parameter addresses and table layout
	// ---------------------------------------------------------------
	localparam int unsigned NREG        = 13;
	localparam logic [15:0] ADDR_FIRST  = 16'h0096;
	localparam logic [15:0] ADDR_LAST   = 16'h00A2;
	localparam logic [15:0] ADDR_STATUS = 16'h0200;
	localparam int unsigned IDX_VREG    = 0;
	localparam int unsigned IDX_SAVE    = 1;
	localparam int unsigned IDX_DELAY   = 2;
	localparam int unsigned IDX_OUTSEL  = 3;
	localparam int unsigned IDX_OUTTIME = 4;
	localparam int unsigned IDX_COUNT   = 5;
	localparam int unsigned IDX_KP      = 6;
	localparam int unsigned IDX_TI      = 7;
	localparam int unsigned IDX_TD      = 8;
	localparam int unsigned IDX_TARGET  = 9;
	localparam int unsigned IDX_CHAN    = 10;
	localparam int unsigned IDX_UPPER   = 11;
	localparam int unsigned IDX_LOWER   = 12;
	localparam logic [15:0] RST_VALS [NREG] = '{
		16'h0001, 16'h0000, 16'h000A, 16'h0000, 16'h0005, 16'h0000, 16'h03E8,
		16'h0032, 16'h0000, 16'h0000, 16'h000A, 16'h0064, 16'h0000};

	// ---------------------------------------------------------------
	// Scaling
	// ---------------------------------------------------------------
	localparam int unsigned ADC_W    = 12;
	localparam int unsigned ADC_MAX  = 4095;
	localparam int          FULL_PM  = 1000;
	localparam int          GAIN_DEN = 1000;
	localparam logic [15:0] FULL     = 16'h03E8;
	localparam logic [15:0] PCT_MUL  = 16'h000A;
	localparam int unsigned CNT_W    = 4;
	localparam int unsigned DIGIT    = 10;
endpackage

// >>> verilog/frsv_tick.sv
`timescale 1ns/1ns
module frsv_tick
#(
	parameter int unsigned DIV = 10
)(
	input  wire logic i_core_clk,
	input  wire logic i_rst,
	input  wire logic i_en,
	output logic      o_tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_q;
	logic          tick_q;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			cnt_q  <= '0;
			tick_q <= 1'b0;
		end
		else if (i_en)
		begin
			tick_q <= (cnt_q == LAST);
			cnt_q  <= (cnt_q == LAST) ? '0 : cnt_q + 1'b1;
		end
		else
			tick_q <= 1'b0;
	end

	assign o_tick = tick_q;
endmodule // frsv_tick

// >>> verilog/frsv_pid.sv
`timescale 1ns/1ns
module frsv_pid
(
	input  wire logic        i_core_clk,
	input  wire logic        i_rst,
	input  wire logic        i_tick,
	input  wire logic        i_slow_tick,
	input  wire logic        i_enable,
	input  wire logic [15:0] i_setpoint,
	input  wire logic [15:0] i_feedback,
	input  wire logic [15:0] i_kp,
	input  wire logic [15:0] i_ti,
	input  wire logic [15:0] i_td,
	output logic      [15:0] o_out
);
	import frsv_pkg::*;

	localparam logic signed [47:0] LIM = $signed({32'h0, FULL});

	logic signed [47:0] err;
	logic signed [47:0] p_full;
	logic signed [47:0] d_full;
	logic signed [47:0] i_next;
	logic signed [47:0] sum;
	logic signed [17:0] err_prev_q;
	logic signed [17:0] int_q;
	logic signed [17:0] d_q;
	logic        [15:0] icnt_q;
	logic        [15:0] out_q;

	function automatic logic signed [17:0] clip(input logic signed [47:0] v);
		if (v > LIM)
			return LIM[17:0];
		else if (v < -LIM)
			return 18'(-LIM);
		else
			return v[17:0];
	endfunction

	always_comb
	begin
		err    = $signed({32'h0, i_setpoint}) - $signed({32'h0, i_feedback});
		p_full = err * $signed({32'h0, i_kp}) / GAIN_DEN;
		d_full = (err - 48'(err_prev_q)) * $signed({32'h0, i_kp}) / GAIN_DEN
			* $signed({32'h0, i_td});
		i_next = 48'(int_q) + p_full;
		sum    = p_full + 48'(int_q) + 48'(d_q);
	end

	// Derivative on 10 ms steps: Td counts in those steps, so Td/dt = Td
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || !i_enable)
		begin
			err_prev_q <= '0;
			int_q      <= '0;
			d_q        <= '0;
			icnt_q     <= '0;
			out_q      <= '0;
		end
		else
		begin
			out_q <= (sum < 0) ? '0 : (sum > LIM) ? FULL : sum[15:0];
			if (i_tick)
			begin
				err_prev_q <= err[17:0];
				d_q        <= (i_td == '0) ? '0 : clip(d_full);
			end
			if (i_ti == '0)
			begin
				int_q  <= '0;
				icnt_q <= '0;
			end
			else if (i_slow_tick)
			begin
				// Adds one P term every Ti: larger Ti, slower integral
				if (icnt_q + 16'h0001 >= i_ti)
				begin
					int_q  <= clip(i_next);
					icnt_q <= '0;
				end
				else
					icnt_q <= icnt_q + 16'h0001;
			end
		end
	end

	assign o_out = out_q;
endmodule // frsv_pid

// >>> verilog/frsv_top.sv
`timescale 1ns/1ns
module frsv_top
#(
	parameter int unsigned BASE_DIV = frsv_pkg::BASE_TICK_CYC
)(
	input  wire logic                       i_core_clk,
	input  wire logic                       i_rst,
	input  wire logic                       i_par_wr,
	input  wire logic                       i_par_rd,
	input  wire logic [15:0]                i_par_addr,
	input  wire logic [15:0]                i_par_wdata,
	output logic      [15:0]                o_par_rdata,
	output logic                            o_par_ack,
	input  wire logic                       i_fault,
	input  wire logic                       i_supply_ok,
	input  wire logic                       i_run_cmd,
	input  wire logic                       i_pid_enable,
	input  wire logic                       i_fault_reset,
	input  wire logic                       i_tracking_start_config,
	input  wire logic                       i_ramping,
	input  wire logic [9:0]                 i_load_pm,
	input  wire logic [frsv_pkg::ADC_W-1:0] i_analog_input_one,
	input  wire logic [frsv_pkg::ADC_W-1:0] i_analog_input_two,
	output logic                            o_drive_en,
	output logic                            o_restart,
	output logic                            o_track_start,
	output logic                            o_lockout,
	output logic                            o_auto_voltage_regulation,
	output logic      [15:0]                o_volt_pm,
	output logic      [15:0]                o_loop_out,
	output logic                            o_pid_active,
	output logic                            o_fb_high,
	output logic                            o_fb_low,
	output logic      [frsv_pkg::CNT_W-1:0] o_restarts_left
);
	import frsv_pkg::*;

	typedef enum logic [2:0] {ST_IDLE, ST_RUN, ST_TRIP, ST_OUTAGE, ST_LOCK} frsv_state_t;

	// ---------------------------------------------------------------
	// Pin synchronisers
	// ---------------------------------------------------------------
	localparam int unsigned NSYNC = 5;

	logic [NSYNC-1:0] pin_raw;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic             fault_s;
	logic             supply_s;
	logic             run_s;
	logic             pid_en_s;
	logic             freset_s;

	assign pin_raw = {i_fault_reset, i_pid_enable, i_run_cmd, i_supply_ok, i_fault};

	for (genvar g = 0; g < NSYNC; g++)
	begin : g_sync
		always_ff @(posedge i_core_clk)
		begin
			if (i_rst)
			begin
				sync1_q[g] <= 1'b0;
				sync2_q[g] <= 1'b0;
			end
			else
			begin
				sync1_q[g] <= pin_raw[g];
				sync2_q[g] <= sync1_q[g];
			end
		end
	end

	assign {freset_s, pid_en_s, run_s, supply_s, fault_s} = sync2_q;

	// ---------------------------------------------------------------
	// Time base: 10 ms and 0.1 s enables
	// ---------------------------------------------------------------
	logic base_tick;
	logic slow_tick;

	frsv_tick #(.DIV(BASE_DIV)) u_base_tick (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_en       (1'b1),
		.o_tick     (base_tick)
	);

	frsv_tick #(.DIV(SLOW_PER_BASE)) u_slow_tick (
		.i_core_clk (i_core_clk),
		.i_rst      (i_rst),
		.i_en       (base_tick),
		.o_tick     (slow_tick)
	);

	// ---------------------------------------------------------------
	// Parameter table
	// ---------------------------------------------------------------
	logic [15:0] regs_q [NREG];
	logic [15:0] off;
	logic        in_map;
	logic [3:0]  idx;
	logic [15:0] status;
	logic [15:0] rdata_q;
	logic        ack_q;

	assign off    = i_par_addr - ADDR_FIRST;
	assign in_map = (i_par_addr >= ADDR_FIRST) && (i_par_addr <= ADDR_LAST);
	assign idx    = off[3:0];

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			regs_q <= RST_VALS;
		else if (i_par_wr && in_map)
			regs_q[idx] <= i_par_wdata;
	end

	// Unmapped reads return zero, writes there are dropped
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			rdata_q <= '0;
			ack_q   <= 1'b0;
		end
		else
		begin
			ack_q <= i_par_wr || i_par_rd;
			if (i_par_rd)
				rdata_q <= in_map ? regs_q[idx] : (i_par_addr == ADDR_STATUS) ? status : '0;
		end
	end

	// ---------------------------------------------------------------
	// Restart supervisor
	// ---------------------------------------------------------------
	frsv_state_t     st_q;
	logic [15:0]     tcnt_q;
	logic [REC_W-1:0] rec_q;
	logic            rec_arm_q;
	logic [CNT_W-1:0] left_q;
	logic            restart_q;
	logic            track_q;
	logic            trip_done;
	logic            outage_ok;
	logic            rec_done;
	logic            count_wr;
	logic            run_prev_q;
	logic            run_edge;

	assign trip_done = (tcnt_q > regs_q[IDX_DELAY]);
	assign outage_ok = regs_q[IDX_OUTSEL][0] && (tcnt_q <= regs_q[IDX_OUTTIME]);
	assign rec_done  = rec_arm_q && slow_tick && (rec_q == REC_W'(RECOVERY_TICKS - 1));
	assign count_wr  = i_par_wr && (i_par_addr == ADDR_FIRST + 16'(IDX_COUNT));
	assign run_edge  = run_s && !run_prev_q;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			st_q      <= ST_IDLE;
			restart_q <= 1'b0;
			track_q   <= 1'b0;
		end
		else
		begin
			restart_q <= 1'b0;
			unique case (st_q)
				ST_IDLE:
					if (run_edge && supply_s)
					begin
						st_q    <= ST_RUN;
						track_q <= 1'b0;
					end
				ST_RUN:
					if (!supply_s)
						st_q <= ST_OUTAGE;
					else if (fault_s)
						st_q <= (left_q == '0) ? ST_LOCK : ST_TRIP;
					else if (!run_s)
						st_q <= ST_IDLE;
				ST_TRIP:
					if (trip_done)
					begin
						st_q      <= ST_RUN;
						restart_q <= 1'b1;
						track_q   <= i_tracking_start_config;
					end
				ST_OUTAGE:
					if (supply_s)
					begin
						// Late return falls back to a normal start from idle
						st_q      <= outage_ok ? ST_RUN : ST_IDLE;
						restart_q <= outage_ok;
						track_q   <= outage_ok;
					end
				ST_LOCK:
					if (freset_s)
						st_q <= ST_IDLE;
			endcase
		end
	end

	// Held run level must not restart after a late return
	// Limitation: a rise while supply is down is lost, cycle run
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			run_prev_q <= 1'b0;
		else
			run_prev_q <= run_s;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || (st_q != ST_TRIP && st_q != ST_OUTAGE))
			tcnt_q <= '0;
		else if (slow_tick && tcnt_q != 16'hFFFF)
			tcnt_q <= tcnt_q + 16'h0001;
	end

	// Window restarts on every automatic restart, dies on any fault
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst || st_q != ST_RUN || fault_s || rec_done)
		begin
			rec_q     <= '0;
			rec_arm_q <= 1'b0;
		end
		else if (restart_q)
		begin
			rec_q     <= '0;
			rec_arm_q <= 1'b1;
		end
		else if (rec_arm_q && slow_tick)
			rec_q <= rec_q + 1'b1;
	end

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
			left_q <= RST_VALS[IDX_COUNT][CNT_W-1:0];
		else if (count_wr)
			left_q <= i_par_wdata[CNT_W-1:0];
		else if (rec_done || (st_q == ST_LOCK && freset_s))
			left_q <= regs_q[IDX_COUNT][CNT_W-1:0];
		else if (st_q == ST_TRIP && trip_done)
			left_q <= left_q - 1'b1;
	end

	// ---------------------------------------------------------------
	// Output voltage
	// ---------------------------------------------------------------
	logic [31:0] load_c;
	logic [31:0] cut;
	logic        avr_q;
	logic [15:0] volt_q;

	assign load_c = (i_load_pm > FULL[9:0]) ? 32'(FULL) : 32'(i_load_pm);
	assign cut    = 32'(regs_q[IDX_SAVE]) * (32'(FULL) - load_c) / 32'(FULL);

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			avr_q  <= RST_VALS[IDX_VREG][0];
			volt_q <= FULL;
		end
		else
		begin
			avr_q <= regs_q[IDX_VREG][0];
			// Light load trims more; ramps always get full voltage
			if (regs_q[IDX_SAVE] == '0 || i_ramping || cut >= 32'(FULL))
				volt_q <= FULL;
			else
				volt_q <= FULL - cut[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Process loop
	// ---------------------------------------------------------------
	logic [15:0] ain1_pm;
	logic [15:0] ain2_pm;
	logic [15:0] chan;
	logic [15:0] sp_pm;
	logic [15:0] fb_pm;
	logic [15:0] pid_out;
	logic [15:0] loop_q;
	logic        pid_act_q;
	logic        fb_hi_q;
	logic        fb_lo_q;

	function automatic logic [15:0] to_pm(input logic [ADC_W-1:0] a);
		logic [31:0] t;
		t = 32'(a) * 32'(FULL) / ADC_MAX;
		return t[15:0];
	endfunction

	assign ain1_pm = to_pm(i_analog_input_one);
	assign ain2_pm = to_pm(i_analog_input_two);
	assign chan    = regs_q[IDX_CHAN];

	always_comb
	begin
		unique case (chan % 16'(DIGIT))
			16'h0001: sp_pm = ain1_pm;
			16'h0002: sp_pm = ain2_pm;
			default:  sp_pm = regs_q[IDX_TARGET];
		endcase
		fb_pm = ((chan / 16'(DIGIT)) % 16'(DIGIT) == 16'h0001) ? ain2_pm : ain1_pm;
	end

	frsv_pid u_pid (
		.i_core_clk  (i_core_clk),
		.i_rst       (i_rst),
		.i_tick      (base_tick),
		.i_slow_tick (slow_tick),
		.i_enable    (pid_en_s),
		.i_setpoint  (sp_pm),
		.i_feedback  (fb_pm),
		.i_kp        (regs_q[IDX_KP]),
		.i_ti        (regs_q[IDX_TI]),
		.i_td        (regs_q[IDX_TD]),
		.o_out       (pid_out)
	);

	// Limit flags never stop the drive, they only report
	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			loop_q    <= '0;
			pid_act_q <= 1'b0;
			fb_hi_q   <= 1'b0;
			fb_lo_q   <= 1'b0;
		end
		else
		begin
			loop_q    <= pid_out;
			pid_act_q <= pid_en_s;
			fb_hi_q   <= fb_pm > regs_q[IDX_UPPER] * PCT_MUL;
			fb_lo_q   <= fb_pm < regs_q[IDX_LOWER] * PCT_MUL;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	logic drive_q;
	logic lock_q;

	always_ff @(posedge i_core_clk)
	begin
		if (i_rst)
		begin
			drive_q <= 1'b0;
			lock_q  <= 1'b0;
		end
		else
		begin
			drive_q <= (st_q == ST_RUN);
			lock_q  <= (st_q == ST_LOCK);
		end
	end

	assign status = {8'h00, left_q, lock_q, drive_q, fb_hi_q, fb_lo_q};

	assign o_par_rdata               = rdata_q;
	assign o_par_ack                 = ack_q;
	assign o_drive_en                = drive_q;
	assign o_restart                 = restart_q;
	assign o_track_start             = track_q;
	assign o_lockout                 = lock_q;
	assign o_auto_voltage_regulation = avr_q;
	assign o_volt_pm                 = volt_q;
	assign o_loop_out                = loop_q;
	assign o_pid_active              = pid_act_q;
	assign o_fb_high                 = fb_hi_q;
	assign o_fb_low                  = fb_lo_q;
	assign o_restarts_left           = left_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (i_rst);

	vreg_follow_a: assert property (
		i_par_wr && i_par_addr == ADDR_FIRST |-> ##2 o_auto_voltage_regulation == $past(i_par_wdata[0], 2))
		else $error("voltage regulation output does not follow selector");
	save_full_a: assert property (
		regs_q[IDX_SAVE] == '0 || i_ramping |=> o_volt_pm == FULL)
		else $error("full voltage not applied");
	trip_delay_a: assert property (
		o_restart && $past(st_q) == ST_TRIP |-> $past(tcnt_q) > $past(regs_q[IDX_DELAY]))
		else $error("fault restart before delay");
	outage_ok_a: assert property (
		o_restart && $past(st_q) == ST_OUTAGE |-> o_track_start && $past(outage_ok))
		else $error("outage restart not allowed");
	trip_track_a: assert property (
		o_restart && $past(st_q) == ST_TRIP |-> o_track_start == $past(i_tracking_start_config))
		else $error("wrong start method");
	recover_a: assert property (
		rec_done && !count_wr |=> left_q == $past(regs_q[IDX_COUNT][CNT_W-1:0]))
		else $error("restart count not restored");
	lock_stop_a: assert property (
		st_q == ST_LOCK ##1 st_q == ST_LOCK |-> !o_drive_en && o_lockout)
		else $error("output during lockout");
	zero_count_a: assert property (
		st_q == ST_RUN && supply_s && fault_s && left_q == '0 |=> st_q == ST_LOCK)
		else $error("restart with no attempts");
	left_dec_a: assert property (
		o_restart && $past(st_q) == ST_TRIP && !$past(count_wr) |-> left_q == $past(left_q) - 1'b1)
		else $error("attempt not consumed");
	pid_off_a: assert property (
		!pid_en_s |-> ##2 o_loop_out == '0)
		else $error("loop output while disabled");
	fb_high_a: assert property (
		fb_pm > regs_q[IDX_UPPER] * PCT_MUL |=> o_fb_high)
		else $error("upper limit flag missing");
	fb_low_a: assert property (
		fb_pm < regs_q[IDX_LOWER] * PCT_MUL |=> o_fb_low)
		else $error("lower limit flag missing");

	trip_restart_c: cover property (o_restart && $past(st_q) == ST_TRIP);
	outage_restart_c: cover property (o_restart && $past(st_q) == ST_OUTAGE);
	lockout_c: cover property ($rose(o_lockout));
	recover_c: cover property (rec_done);
endmodule // frsv_top

// >>> tb/frsv_plant.sv
`timescale 1ns/1ns
module frsv_plant
(
	input  wire logic        i_core_clk,
	input  wire logic [15:0] i_fb_one_pm,
	input  wire logic [15:0] i_fb_two_pm,
	output logic             o_fault,
	output logic             o_supply_ok,
	output logic      [11:0] o_ai_one,
	output logic      [11:0] o_ai_two
);
	initial
	begin
		o_fault = 1'b0;
		o_supply_ok = 1'b1;
	end
	// ---------------------------------------------------------------
	// Transmitters
	// ---------------------------------------------------------------
	// 4..20 mA loop mapped onto the full ADC span, 0.1 % input
	assign o_ai_one = 12'(32'(i_fb_one_pm) * 4095 / 1000);
	assign o_ai_two = 12'(32'(i_fb_two_pm) * 4095 / 1000);
	// ---------------------------------------------------------------
	// Inverter stage
	// ---------------------------------------------------------------
	// Trip held long enough to pass the input synchroniser
	task automatic trip();
		@(posedge i_core_clk);
		o_fault <= 1'b1;
		repeat (6) @(posedge i_core_clk);
		o_fault <= 1'b0;
	endtask
	task automatic outage(input int cyc);
		@(posedge i_core_clk);
		o_supply_ok <= 1'b0;
		repeat (cyc) @(posedge i_core_clk);
		o_supply_ok <= 1'b1;
	endtask
endmodule // frsv_plant

// >>> tb/test_fault_restart_pid_supervisor.sv
`timescale 1ns/1ns
module test_fault_restart_pid_supervisor;
	import frsv_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run = 1'b0, pen = 1'b0;
	logic fres = 1'b0, trk = 1'b0, ramp = 1'b0, flt, sok, ack, drv, rsp, tst, lck, auto_voltage_regulation, pact, fbh, fbl;
	logic [15:0] adr = 16'h0000, wd = 16'h0000, fb1 = 16'h0000, fb2 = 16'h0000, rdat, volt, lout;
	logic [9:0]  load = 10'h000;
	logic [11:0] ai1, ai2;
	logic [3:0]  left;
	logic [16:0] exp_q[$];
	logic [16:0] note;
	int num_errors = 0, num_checks = 0, n, e;
	always #4 clk = ~clk;
	frsv_plant plant (.i_core_clk(clk), .i_fb_one_pm(fb1), .i_fb_two_pm(fb2), .o_fault(flt),
		.o_supply_ok(sok), .o_ai_one(ai1), .o_ai_two(ai2));
	frsv_top #(.BASE_DIV(10)) dut_u (.i_core_clk(clk), .i_rst(rst), .i_par_wr(wr), .i_par_rd(rd),
		.i_par_addr(adr), .i_par_wdata(wd), .o_par_rdata(rdat), .o_par_ack(ack), .i_fault(flt),
		.i_supply_ok(sok), .i_run_cmd(run), .i_pid_enable(pen), .i_fault_reset(fres),
		.i_tracking_start_config(trk), .i_ramping(ramp), .i_load_pm(load), .i_analog_input_one(ai1),
		.i_analog_input_two(ai2), .o_drive_en(drv), .o_restart(rsp), .o_track_start(tst),
		.o_lockout(lck), .o_auto_voltage_regulation(auto_voltage_regulation), .o_volt_pm(volt), .o_loop_out(lout),
		.o_pid_active(pact), .o_fb_high(fbh), .o_fb_low(fbl), .o_restarts_left(left));
	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	task automatic chk(input string nm, input logic [15:0] ex, input logic [15:0] got);
		num_checks++;
		if (got !== ex)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [16:0] nt);
		@(posedge clk);
		wr <= w;
		rd <= !w;
		adr <= a;
		wd <= d;
		exp_q.push_back(nt);
		@(posedge clk);
		wr <= 1'b0;
		rd <= 1'b0;
	endtask
	task automatic wreg(input int i, input logic [15:0] d);
		acc(1'b1, ADDR_FIRST + 16'(i), d, 17'h00000);
	endtask
	task automatic rreg(input logic [15:0] a, input logic [15:0] ex);
		acc(1'b0, a, 16'h0000, {1'b1, ex});
	endtask
	// Bounded wait for the restart pulse; 1000 means none came
	task automatic wait_rst(output int cnt);
		cnt = 0;
		while (rsp !== 1'b1 && cnt < 1000)
		begin
			@(negedge clk);
			cnt++;
		end
	endtask
	task automatic start_run();
		@(posedge clk);
		run <= 1'b0;
		repeat (5) @(posedge clk);
		run <= 1'b1;
		repeat (20) @(negedge clk);
	endtask
	task automatic pulse_reset();
		@(posedge clk);
		fres <= 1'b1;
		repeat (5) @(posedge clk);
		fres <= 1'b0;
		repeat (5) @(negedge clk);
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(negedge clk)
		if (ack === 1'b1)
		begin
			note = exp_q.pop_front();
			if (note[16])
				chk("read data", note[15:0], rdat);
		end
	initial
	begin
		repeat (90000) @(posedge clk);
		num_errors++;
		summarize();
	end
	// ---------------------------------------------------------------
	// Tests
	// ---------------------------------------------------------------
	initial
	begin
		void'($urandom(32'hdc18));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		chk("voltage regulation", 16'h0001, 16'(auto_voltage_regulation));
		chk("voltage command", 16'h03E8, volt);
		for (int i = 0; i < NREG; i++)
			rreg(ADDR_FIRST + 16'(i), RST_VALS[i]);
		rreg(16'h00A3, 16'h0000);
		rreg(16'h0095, 16'h0000);
		acc(1'b1, ADDR_STATUS, 16'hFFFF, 17'h00000);
		rreg(ADDR_STATUS, 16'h0000);
		for (int i = 0; i < NREG; i++)
		begin
			e = $urandom;
			wreg(i, 16'(e));
			rreg(ADDR_FIRST + 16'(i), 16'(e));
			wreg(i, RST_VALS[i]);
		end
		$display("test registers done");
		wreg(IDX_VREG, 16'h0000);
		repeat (3) @(negedge clk);
		chk("voltage regulation", 16'h0000, 16'(auto_voltage_regulation));
		wreg(IDX_VREG, 16'h0001);
		start_run();
		wreg(IDX_SAVE, 16'h00C8);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			load <= 10'($urandom_range(0, 1000));
			ramp <= (k == 1);
			repeat (30) @(negedge clk);
			e = (k == 1) ? 1000 : 1000 - 200 * (1000 - int'(load)) / 1000;
			chk("saving voltage", 16'(e), volt);
		end
		wreg(IDX_SAVE, 16'h0000);
		repeat (30) @(negedge clk);
		chk("saving off voltage", 16'h03E8, volt);
		$display("test voltage done");
		wreg(IDX_DELAY, 16'h0002);
		wreg(IDX_COUNT, 16'h0002);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			trk <= k[0];
			fork
				plant.trip();
			join_none
			repeat (20) @(negedge clk);
			chk("drive in trip", 16'h0000, 16'(drv));
			wait_rst(n);
			chk("restart wait", (k < 2) ? 16'h0001 : 16'h0000, 16'(n > 180 && n <= 300));
			if (k < 2)
			begin
				chk("tracking start", 16'(k), 16'(tst));
				chk("restarts left", 16'(1 - k), 16'(left));
				repeat (50) @(negedge clk);
				chk("drive restarted", 16'h0001, 16'(drv));
			end
		end
		chk("lockout", 16'h0001, 16'(lck));
		chk("locked drive", 16'h0000, 16'(drv));
		pulse_reset();
		chk("lockout cleared", 16'h0000, 16'(lck));
		chk("reloaded left", 16'h0002, 16'(left));
		$display("test fault restart done");
		wreg(IDX_COUNT, 16'h0000);
		start_run();
		fork
			plant.trip();
		join_none
		wait_rst(n);
		chk("no restart at zero", 16'd1000, 16'(n));
		chk("stopped at zero", 16'h0000, 16'(drv));
		pulse_reset();
		wreg(IDX_COUNT, 16'h0001);
		start_run();
		fork
			plant.trip();
		join_none
		wait_rst(n);
		chk("last attempt used", 16'h0000, 16'(left));
		repeat (59800) @(negedge clk);
		chk("left before window", 16'h0000, 16'(left));
		repeat (400) @(negedge clk);
		chk("left after window", 16'h0001, 16'(left));
		$display("test recovery done");
		for (int k = 0; k < 3; k++)
		begin
			wreg(IDX_OUTSEL, {15'h0000, k != 2});
			fork
				plant.outage((k == 1) ? 900 : 300);
			join_none
			wait_rst(n);
			chk("outage restart", 16'(k == 0), 16'(n < 1000));
			if (k == 0)
				chk("outage tracking", 16'h0001, 16'(tst));
			repeat (50) @(negedge clk);
			chk("drive after outage", 16'(k == 0), 16'(drv));
			start_run();
			chk("normal start", 16'h0001, 16'(drv));
		end
		$display("test outage done");
		chk("loop idle", 16'h0000, lout);
		chk("loop inactive", 16'h0000, 16'(pact));
		wreg(IDX_KP, 16'h01F4);
		wreg(IDX_TI, 16'h0000);
		wreg(IDX_TARGET, 16'h02BC);
		@(posedge clk);
		pen <= 1'b1;
		for (int k = 0; k < 4; k++)
		begin
			wreg(IDX_CHAN, (k == 0) ? 16'd0 : (k == 1) ? 16'd11 : (k == 2) ? 16'd2 : 16'd1);
			fb1 <= (k == 1 || k == 3) ? 16'h03E8 : 16'h0000;
			fb2 <= (k == 2) ? 16'h03E8 : 16'h0000;
			repeat (200) @(negedge clk);
			chk("loop output", (k == 0) ? 16'd350 : (k == 3) ? 16'd0 : 16'd500, lout);
			chk("loop active", 16'h0001, 16'(pact));
		end
		wreg(IDX_CHAN, 16'd10);
		wreg(IDX_UPPER, 16'd50);
		wreg(IDX_LOWER, 16'd30);
		for (int k = 0; k < 3; k++)
		begin
			@(posedge clk);
			fb2 <= (k == 0) ? 16'd600 : (k == 1) ? 16'd200 : 16'd400;
			repeat (100) @(negedge clk);
			chk("upper flag", 16'(k == 0), 16'(fbh));
			chk("lower flag", 16'(k == 1), 16'(fbl));
			chk("drive kept", 16'h0001, 16'(drv));
		end
		for (int k = 0; k < 3; k++)
		begin
			wreg(IDX_TI, (k == 0) ? 16'h0032 : (k == 1) ? 16'h0001 : 16'h0000);
			repeat ((k == 2) ? 10 : 1000) @(negedge clk);
			chk("integral output", (k == 1) ? 16'h03E8 : 16'h0096, lout);
		end
		$display("test loop done");
		summarize();
	end
endmodule // test_fault_restart_pid_supervisor
